//--- rtl/cils_regs.svh
`ifndef CILS_REGS_SVH
`define CILS_REGS_SVH
// current limits in mA
`define CILS_CUR_100MA 12'h064
`define CILS_CUR_500MA 12'h1F4
`define CILS_CUR_1500MA 12'h5DC
`define CILS_CUR_2A 12'h7D0
`define CILS_CUR_ZERO 12'h000
// thresholds in mV
`define CILS_VREG_4360MV 13'h1108
`define CILS_VREG_4680MV 13'h1248
`define CILS_VREG_NONE 13'h0000
// select pin codes {high,low}
`define CILS_SEL_500 2'h0
`define CILS_SEL_EXT 2'h1
`define CILS_SEL_100 2'h2
`define CILS_SEL_HIZ 2'h3
// port class codes
`define CILS_PORT_NONE 3'h0
`define CILS_PORT_DCP 3'h1
`define CILS_PORT_SDP 3'h2
`define CILS_PORT_CDP 3'h3
`define CILS_PORT_NONSTD 3'h4
// detection countdown loaded on entry, a timeout leaves the state after 17 cycles
`define CILS_DET_CYCLES 8'h10
`endif

//--- rtl/cils_pkg.sv
package cils_pkg;
  typedef enum logic [1:0] {
    CILS_DET_IDLE = 2'b00,
    CILS_DET_RUN = 2'b01,
    CILS_DET_DONE = 2'b10
  } cils_det_state_t;
  typedef enum logic [1:0] {
    CILS_PH_TRICKLE = 2'b00,
    CILS_PH_PRE = 2'b01,
    CILS_PH_CC = 2'b10,
    CILS_PH_CV = 2'b11
  } cils_phase_t;
endpackage

//--- rtl/cils_loop_select.sv
`timescale 1ns/1ps
// ************************************************************
// minimum duty loop picker
// ************************************************************
module cils_loop_select #(
  parameter int LOOPS = 7,
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [LOOPS*DW-1:0] loop_duty,
  output logic [2:0] active_loop,
  output logic [DW-1:0] active_duty
);
  typedef struct packed {
    logic [2:0] idx;
    logic [DW-1:0] duty;
  } cils_ls_t;
  cils_ls_t s_q, s_d;
  logic [DW-1:0] best [LOOPS];
  logic [2:0] bidx [LOOPS];

  // chain of compares, smallest duty wins, lower index on tie
  generate
    for (genvar i = 0; i < LOOPS; i++) begin : g_cmp
      if (i == 0) begin : g_first
        assign best[0] = loop_duty[DW-1:0];
        assign bidx[0] = 3'h0;
      end else begin : g_rest
        assign best[i] = (loop_duty[i*DW +: DW] < best[i-1]) ?
          loop_duty[i*DW +: DW] : best[i-1]; // R5
        assign bidx[i] = (loop_duty[i*DW +: DW] < best[i-1]) ?
          3'(i) : bidx[i-1];
      end
    end
  endgenerate

  // register the winner
  always_comb begin
    s_d.idx = bidx[LOOPS-1];
    s_d.duty = best[LOOPS-1];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active_loop = s_q.idx;
  assign active_duty = s_q.duty;
endmodule

//--- rtl/cils_top.sv
// Functional notes
// R1: host mode while accessed and watchdog alive
// R2: host mode applies host written parameters
// R3: standalone uses resistor strapped limits
// R4: dedicated charge port uses resistor defaults
// R5: smallest duty loop becomes active
// R6: four phases, thermal cut of current
// R7: select pins map to limit and threshold
// R8: detection first, pins wait for change
// R9: power good released after detection
// R10: classify DCP SDP CDP, dead battery
// R11: nonstandard adapter gives 500mA
// R12: shorted pins give 2A and 4.68V
// R13: shorted charge resistor faults, suspends
// R14: floating limit pin with external gives zero
// R15: auto detection only in standalone
// R16: forced detection request in host mode
// R17: capture pins at detection end
`timescale 1ns/1ps
`include "cils_regs.svh"
module cils_top #(
  parameter bit HAS_DETECT = 1'b1,
  parameter bit HAS_SEL_PINS = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic i2c_access,
  input wire logic watchdog_en,
  input wire logic watchdog_expired,
  input wire logic [11:0] host_input_limit,
  input wire logic [12:0] host_vreg_threshold,
  input wire logic [11:0] host_charge_current,
  input wire logic host_ext_charge_sel,
  input wire logic force_port_detection,
  input wire logic current_sel_low_pin,
  input wire logic current_sel_high_pin,
  input wire logic [11:0] input_limit_resistor_val,
  input wire logic input_limit_resistor_pin_short,
  input wire logic input_limit_resistor_pin_float,
  input wire logic [11:0] charge_current_resistor_val,
  input wire logic charge_current_resistor_pin_short,
  input wire logic [12:0] input_regulation_divider_val,
  input wire logic input_regulation_divider_pin_short,
  input wire logic vbus_present,
  input wire logic det_result_valid,
  input wire logic [2:0] det_result_class,
  input wire logic battery_good,
  input wire logic die_over_temp,
  input wire cils_pkg::cils_phase_t charge_phase,
  input wire logic [55:0] loop_duty,
  output logic host_mode,
  output logic detect_busy,
  output logic [2:0] port_class,
  output logic pin_control,
  output logic [11:0] input_limit,
  output logic input_hiz,
  output logic [12:0] input_voltage_regulation_threshold,
  output logic [11:0] charge_current,
  output logic charge_fault,
  output logic charge_suspend,
  output logic thermal_reduce,
  output logic power_good_output_oe,
  output logic [2:0] active_loop,
  output logic [7:0] active_duty
);
  import cils_pkg::*;

  typedef struct packed {
    logic host;
    cils_det_state_t det;
    logic [7:0] cnt;
    logic done;
    logic [2:0] cls;
    logic [1:0] sel_cap;
    logic pinctl;
    logic [11:0] in_lim;
    logic hiz;
    logic [12:0] vreg;
    logic [11:0] ichg;
    logic fault;
    logic susp;
    logic therm;
    logic pwr_ok_oe;
    logic busy;
  } cils_state_t;

  cils_state_t s_q, s_d;

  // ************************************************************
  // per-source settings
  // ************************************************************
  logic [1:0] sel_now;
  logic [11:0] ext_lim;
  logic [12:0] ext_vreg;
  logic [11:0] ext_ichg;
  logic [11:0] std_lim;
  logic std_hiz;
  logic [12:0] std_vreg;
  logic [11:0] pin_lim;
  logic pin_hiz;
  logic [12:0] pin_vreg;

  assign sel_now = {current_sel_high_pin, current_sel_low_pin};

  // strapped values with shorted pin defaults
  always_comb begin
    ext_lim = input_limit_resistor_pin_short ? `CILS_CUR_2A :
      input_limit_resistor_val; // R12
    ext_vreg = input_regulation_divider_pin_short ? `CILS_VREG_4680MV :
      input_regulation_divider_val; // R12
    ext_ichg = charge_current_resistor_val;
  end

  // select pin decode
  always_comb begin
    pin_hiz = 1'b0;
    pin_lim = `CILS_CUR_500MA;
    pin_vreg = `CILS_VREG_4360MV;
    unique case (sel_now) // R7
      `CILS_SEL_500: begin
        pin_lim = `CILS_CUR_500MA;
        pin_vreg = `CILS_VREG_4360MV;
      end
      `CILS_SEL_EXT: begin
        pin_lim = ext_lim;
        pin_vreg = ext_vreg;
      end
      `CILS_SEL_100: begin
        pin_lim = `CILS_CUR_100MA;
        pin_vreg = `CILS_VREG_4360MV;
      end
      `CILS_SEL_HIZ: begin
        pin_lim = `CILS_CUR_ZERO;
        pin_vreg = `CILS_VREG_NONE;
        pin_hiz = 1'b1;
      end
    endcase
  end

  // standalone limit from detected port class
  always_comb begin
    std_hiz = 1'b0;
    std_lim = ext_lim; // R3
    std_vreg = ext_vreg; // R3
    case (s_q.cls) // R10
      `CILS_PORT_DCP: std_lim = ext_lim; // R4
      `CILS_PORT_CDP: std_lim = battery_good ? `CILS_CUR_1500MA :
        `CILS_CUR_100MA;
      `CILS_PORT_SDP: begin
        std_lim = battery_good ? `CILS_CUR_ZERO : `CILS_CUR_100MA;
        std_hiz = battery_good;
      end
      `CILS_PORT_NONSTD: std_lim = `CILS_CUR_500MA; // R11
      default: std_lim = ext_lim;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    // host mode tracking
    s_d.host = i2c_access && !(watchdog_en && watchdog_expired); // R1
    // detection sequencer
    unique case (s_q.det)
      CILS_DET_IDLE: begin
        if (HAS_DETECT && ((vbus_present && !s_q.host && !s_q.done) ||
            (s_q.host && force_port_detection))) begin // R15 R16
          s_d.det = CILS_DET_RUN;
          s_d.cnt = `CILS_DET_CYCLES;
        end
      end
      CILS_DET_RUN: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
        if (det_result_valid || s_q.cnt == 8'h00) begin
          s_d.det = CILS_DET_DONE;
          s_d.cls = det_result_valid ? det_result_class :
            `CILS_PORT_SDP; // R10
        end
      end
      CILS_DET_DONE: begin
        s_d.done = 1'b1;
        s_d.sel_cap = sel_now; // R17
        s_d.det = CILS_DET_IDLE;
      end
      default: s_d.det = CILS_DET_IDLE;
    endcase
    // supply loss outside host mode clears done, a finishing detection still sets it
    if (!vbus_present && !s_q.host && s_q.det != CILS_DET_DONE) begin
      s_d.done = 1'b0;
    end
    // busy flag taken from the next detection state
    s_d.busy = (s_d.det != CILS_DET_IDLE);
    // with detection, pins take effect only after a post-detection change; without it, at once if HAS_SEL_PINS
    if (!HAS_DETECT) begin
      s_d.pinctl = HAS_SEL_PINS;
    end else if (HAS_SEL_PINS && s_q.done && s_q.det == CILS_DET_IDLE &&
        sel_now != s_q.sel_cap) begin
      s_d.pinctl = 1'b1; // R8 R17
    end
    // power good held off while any detection runs and until done
    s_d.pwr_ok_oe = (!HAS_DETECT || (s_q.done && !s_d.busy)) &&
      vbus_present; // R9
    // limit selection
    if (s_q.host) begin
      s_d.in_lim = host_input_limit; // R2
      s_d.vreg = host_vreg_threshold; // R2
      s_d.hiz = 1'b0;
    end else if (s_q.pinctl) begin
      s_d.in_lim = pin_lim;
      s_d.vreg = pin_vreg;
      s_d.hiz = pin_hiz;
    end else begin
      s_d.in_lim = std_lim;
      s_d.vreg = std_vreg;
      s_d.hiz = std_hiz;
    end
    // charge current, faults and thermal fold back
    s_d.fault = charge_current_resistor_pin_short; // R13
    s_d.susp = charge_current_resistor_pin_short || s_d.hiz; // R13
    s_d.therm = die_over_temp; // R6
    if (s_d.susp) begin
      s_d.ichg = `CILS_CUR_ZERO;
    end else if (s_q.host && host_ext_charge_sel &&
        input_limit_resistor_pin_float) begin
      s_d.ichg = `CILS_CUR_ZERO; // R14
    end else begin
      s_d.ichg = (s_q.host && !host_ext_charge_sel) ?
        host_charge_current : ext_ichg;
      if (die_over_temp && charge_phase inside {CILS_PH_TRICKLE,
          CILS_PH_PRE, CILS_PH_CC, CILS_PH_CV}) begin
        s_d.ichg = {1'b0, s_d.ichg[11:1]}; // R6
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // loop arbitration
  cils_loop_select #(.LOOPS(7), .DW(8)) u_loop (
    .mclk(mclk),
    .rst(rst),
    .loop_duty(loop_duty),
    .active_loop(active_loop),
    .active_duty(active_duty)
  ); // R5

  assign host_mode = s_q.host;
  assign detect_busy = s_q.busy;
  assign port_class = s_q.cls;
  assign pin_control = s_q.pinctl;
  assign input_limit = s_q.in_lim;
  assign input_hiz = s_q.hiz;
  assign input_voltage_regulation_threshold = s_q.vreg;
  assign charge_current = s_q.ichg;
  assign charge_fault = s_q.fault;
  assign charge_suspend = s_q.susp;
  assign thermal_reduce = s_q.therm;
  assign power_good_output_oe = s_q.pwr_ok_oe;
endmodule

//--- test/cils_chk.sv
`timescale 1ns/1ps
// ****
// output checks
// ****
module cils_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic i2c_access,
  input wire logic watchdog_en,
  input wire logic watchdog_expired,
  input wire logic current_sel_low_pin,
  input wire logic current_sel_high_pin,
  input wire logic input_limit_resistor_pin_short,
  input wire logic charge_current_resistor_pin_short,
  input wire logic die_over_temp,
  input wire logic [55:0] loop_duty,
  input wire logic host_mode,
  input wire logic detect_busy,
  input wire logic pin_control,
  input wire logic [11:0] input_limit,
  input wire logic input_hiz,
  input wire logic charge_fault,
  input wire logic charge_suspend,
  input wire logic thermal_reduce,
  input wire logic power_good_output_oe,
  input wire logic [2:0] active_loop,
  input wire logic [7:0] active_duty
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [1:0] sel;
  logic sa;
  // pin code and standalone pin control
  assign sel = {current_sel_high_pin, current_sel_low_pin};
  assign sa = !host_mode && pin_control && !rst;
  // smallest of the seven duties
  function automatic logic [7:0] mind(logic [55:0] d);
    mind = d[7:0];
    for (int i = 1; i < 7; i++)
      if (d[8*i+:8] < mind) mind = d[8*i+:8];
  endfunction
  // index of the smallest duty, lowest index on a tie
  function automatic logic [2:0] midx(logic [55:0] d);
    logic [7:0] m;
    m = d[7:0];
    midx = 3'h0;
    for (int i = 1; i < 7; i++)
      if (d[8*i+:8] < m) begin
        m = d[8*i+:8];
        midx = 3'(i);
      end
  endfunction
  a_host_mode: assert property (
    $past(!rst) |-> host_mode ==
    $past(i2c_access && !(watchdog_en && watchdog_expired)))
    else $error("host mode wrong");
  a_min_loop: assert property (
    $past(!rst) |-> active_duty == $past(mind(loop_duty)))
    else $error("active duty not minimum");
  a_loop_index: assert property (
    $past(!rst) |-> active_loop == $past(midx(loop_duty)))
    else $error("active loop index wrong");
  a_pwr_good_hold: assert property (
    detect_busy |-> !power_good_output_oe)
    else $error("power good released in detection");
  a_det_bound: assert property (
    $rose(detect_busy) |-> ##[1:18] !detect_busy)
    else $error("detection too long");
  a_sel_hiz: assert property (
    $past(sa && sel == 2'h3) |-> input_hiz && input_limit == 12'h000)
    else $error("hi-z code not applied");
  a_input_limit_resistor_pin_short: assert property (
    $past(sa && sel == 2'h1 && input_limit_resistor_pin_short)
    |-> input_limit == 12'h7D0)
    else $error("shorted limit pin not 2A");
  a_chg_res_fault: assert property (
    $past(charge_current_resistor_pin_short && !rst)
    |-> charge_fault && charge_suspend)
    else $error("charge resistor short not faulted");
  a_thermal_cut: assert property (
    $past(!rst) |-> thermal_reduce == $past(die_over_temp))
    else $error("thermal reduce wrong");
  c_pwr_good: cover property ($rose(power_good_output_oe));
  c_forced: cover property (host_mode && $rose(detect_busy));
  c_pins: cover property ($rose(pin_control));
  c_host: cover property ($rose(host_mode));
endmodule

bind cils_top cils_chk i_chk (.*);

//--- test/cils_port.sv
`timescale 1ns/1ps
// ****
// charging port detector model
// ****
module cils_port (
  input wire logic mclk,
  input wire logic detect_busy,
  input wire logic [2:0] cls,
  output logic det_result_valid,
  output logic [2:0] det_result_class
);
  int n = 0;
  logic valid_q = 1'b0;
  logic [2:0] class_q = 3'h5;
  assign det_result_valid = valid_q;
  assign det_result_class = class_q;
  // answers once, class 0 stays silent
  always @(negedge mclk) begin
    n = detect_busy ? n + 1 : 0;
    valid_q <= detect_busy && n == 3 && cls != 3'h0;
    class_q <= n == 3 ? cls : ~class_q;
  end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module tb;
  import cils_pkg::*;
  logic mclk = 0, rst = 1, i2c_access = 0, watchdog_en = 0;
  logic watchdog_expired = 0, host_ext_charge_sel = 0;
  logic force_port_detection = 0, current_sel_low_pin = 0;
  logic current_sel_high_pin = 0, input_limit_resistor_pin_short = 0;
  logic input_limit_resistor_pin_float = 0, vbus_present = 0;
  logic charge_current_resistor_pin_short = 0, battery_good = 0;
  logic input_regulation_divider_pin_short = 0, die_over_temp = 0;
  logic [11:0] host_input_limit = 12'h3E8, host_charge_current = 12'h1F4;
  logic [11:0] input_limit_resistor_val, charge_current_resistor_val;
  logic [12:0] host_vreg_threshold = 13'h1194, input_regulation_divider_val;
  logic [55:0] loop_duty = 0;
  cils_phase_t charge_phase = CILS_PH_CC;
  logic [2:0] cls = 3'h1, det_result_class, port_class, active_loop;
  logic det_result_valid, host_mode, detect_busy, pin_control, input_hiz;
  logic charge_fault, charge_suspend, thermal_reduce, power_good_output_oe;
  logic [11:0] input_limit, charge_current;
  logic [12:0] input_voltage_regulation_threshold, el[4], et[4];
  logic [7:0] active_duty;
  logic [31:0] rs = 32'hB782F684;
  int n_fail = 0, check_count = 0, cyc = 0, qk[$];
  logic [12:0] qe[$];
  string nm[7] = '{"limit", "thresh", "class", "pwr_good", "chg", "host",
    "busy"};
  event ev;
  cils_top i_cils_top (.*);
  cils_port i_cils_port (.*);
  initial forever #2.5 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [12:0] obs(int k);
    case (k)
      0: return {1'b0, input_limit};
      1: return input_voltage_regulation_threshold;
      2: return {10'h0, port_class};
      3: return {12'h0, power_good_output_oe};
      4: return {1'b0, charge_current};
      5: return {12'h0, host_mode};
      default: return {12'h0, detect_busy};
    endcase
  endfunction
  // expected limit per port class and battery
  function automatic logic [12:0] lim(int c, bit b);
    case (c)
      1: return {1'b0, input_limit_resistor_val};
      3: return b ? 13'h5DC : 13'h064;
      4: return 13'h1F4;
      default: return b ? 13'h000 : 13'h064;
    endcase
  endfunction
  task automatic check(logic [12:0] seen, logic [12:0] exp, int k);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm[k], exp, seen);
    end
  endtask
  task automatic exp_v(int k, logic [12:0] e);
    qk.push_back(k);
    qe.push_back(e);
  endtask
  task automatic go(int n);
    repeat (n) @(negedge mclk);
    -> ev;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // monitor checks every queued note, oldest first, at each event
  initial forever begin
    int k;
    @ev;
    while (qk.size() > 0) begin
      k = qk.pop_front();
      check(obs(k), qe.pop_front(), k);
    end
  end
  // random loop duties and phase
  always @(negedge mclk) begin
    loop_duty <= 56'({rnd(), rnd()});
    charge_phase <= cils_phase_t'(rs[1:0]);
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    input_limit_resistor_val = 12'(rnd() % 1900 + 100);
    charge_current_resistor_val = 12'(rnd() % 1900 + 100);
    input_regulation_divider_val = 13'(rnd() % 2000 + 3900);
    repeat (20) @(negedge mclk);
    rst = 0;
    // every class with dead and good battery, pins untouched
    for (int c = 0; c < 5; c++)
      for (int b = 0; b < 2; b++) begin
        vbus_present = 0;
        cls = c[2:0];
        battery_good = b[0];
        repeat (3) @(negedge mclk);
        vbus_present = 1;
        repeat (25) @(negedge mclk);
        exp_v(2, c == 0 ? 13'h2 : 13'(c));
        exp_v(0, lim(c, b[0]));
        exp_v(3, 13'h1);
        exp_v(4, (c == 0 || c == 2) && b == 1 ? 13'h0 :
          {1'b0, charge_current_resistor_val});
        go(1);
      end
    die_over_temp = 1;
    exp_v(4, {2'b0, charge_current_resistor_val[11:1]});
    go(3);
    die_over_temp = 0;
    el = '{13'h1F4, {1'b0, input_limit_resistor_val}, 13'h064, 13'h0};
    et = '{13'h1108, input_regulation_divider_val, 13'h1108, 13'h0};
    // select codes after a change from the captured 00
    for (int i = 1; i < 5; i++) begin
      {current_sel_high_pin, current_sel_low_pin} = 2'(i);
      exp_v(0, el[i%4]);
      exp_v(1, et[i%4]);
      go(4);
    end
    {current_sel_high_pin, current_sel_low_pin} = 2'h1;
    input_limit_resistor_pin_short = 1;
    input_regulation_divider_pin_short = 1;
    charge_current_resistor_pin_short = 1;
    exp_v(0, 13'h7D0);
    exp_v(1, 13'h1248);
    go(4);
    {input_limit_resistor_pin_short, charge_current_resistor_pin_short} = 0;
    input_regulation_divider_pin_short = 0;
    i2c_access = 1;
    watchdog_en = 1;
    exp_v(5, 13'h1);
    exp_v(0, {1'b0, host_input_limit});
    exp_v(1, host_vreg_threshold);
    exp_v(4, {1'b0, host_charge_current});
    go(4);
    host_ext_charge_sel = 1;
    input_limit_resistor_pin_float = 1;
    force_port_detection = 1;
    exp_v(6, 13'h1);
    exp_v(4, 13'h0);
    go(2);
    force_port_detection = 0;
    repeat (25) @(negedge mclk);
    watchdog_expired = 1;
    exp_v(5, 13'h0);
    go(3);
    @(negedge mclk);
    tally_and_finish();
  end
endmodule
